/* common/cexec_pkg.sv */
// constants for the compact-isa execution unit
package cexec_pkg;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_INSN   = 8'h04;
	localparam logic [7:0]  OFF_PC     = 8'h08;
	localparam logic [7:0]  OFF_OPA_L  = 8'h0c;
	localparam logic [7:0]  OFF_OPA_H  = 8'h10;
	localparam logic [7:0]  OFF_OPB_L  = 8'h14;
	localparam logic [7:0]  OFF_OPB_H  = 8'h18;
	localparam logic [7:0]  OFF_COND   = 8'h1c;
	localparam logic [7:0]  OFF_BOT_L  = 8'h20;
	localparam logic [7:0]  OFF_BOT_H  = 8'h24;
	localparam logic [7:0]  OFF_UPP_L  = 8'h28;
	localparam logic [7:0]  OFF_UPP_H  = 8'h2c;
	localparam logic [7:0]  OFF_STATUS = 8'h30;
	localparam logic [7:0]  OFF_GPR_L  = 8'h34;
	localparam logic [7:0]  OFF_GPR_H  = 8'h38;
	localparam logic [31:0] RST_PC     = 32'h0000_0000;
	localparam logic [2:0]  RST_CTRL   = 3'h0;
	localparam int          CTRL_ISA   = 0;
	localparam int          CTRL_M64   = 1;
	localparam int          CTRL_KERN  = 2;
	localparam int          ST_RI      = 0;
	localparam int          ST_ADDR    = 1;
	localparam int          ST_BRK     = 2;
	localparam int          ST_BUSY    = 3;
	localparam int          ST_EXT     = 4;
	localparam int          ST_SLOT    = 5;
	localparam int          ST_CODE    = 8;
	localparam logic [6:0]  DIV_LAST   = 7'h3f;
	localparam logic [31:0] LEN_HALF   = 32'h0000_0002;
	localparam logic [31:0] LEN_WORD   = 32'h0000_0004;
	localparam logic [4:0]  OP_MOVE_BOT   = 5'h00;
	localparam logic [4:0]  OP_MOVE_UPP   = 5'h01;
	localparam logic [4:0]  OP_SMUL       = 5'h02;
	localparam logic [4:0]  OP_UMUL       = 5'h03;
	localparam logic [4:0]  OP_SDIV       = 5'h04;
	localparam logic [4:0]  OP_UDIV       = 5'h05;
	localparam logic [4:0]  OP_JUMP_LINK  = 5'h06;
	localparam logic [4:0]  OP_JUMP_XCHG  = 5'h07;
	localparam logic [4:0]  OP_REG_JUMP   = 5'h08;
	localparam logic [4:0]  OP_REG_JLINK  = 5'h09;
	localparam logic [4:0]  OP_BR_RZERO   = 5'h0a;
	localparam logic [4:0]  OP_BR_RNZ     = 5'h0b;
	localparam logic [4:0]  OP_BR_CZERO   = 5'h0c;
	localparam logic [4:0]  OP_BR_CNZ     = 5'h0d;
	localparam logic [4:0]  OP_BR_ALWAYS  = 5'h0e;
	localparam logic [4:0]  OP_BREAKPT    = 5'h0f;
	localparam logic [4:0]  OP_EXT_PREFIX = 5'h10;
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_div  = 2'b10
	} div_state_e;
endpackage : cexec_pkg

/* rtl/compact_isa_exec.sv */
// compact-isa execution unit with apb register access
//
// Decided for this implementation: the register offsets and the APB register port.

module compact_isa_exec import cexec_pkg::*; #(
	parameter logic [31:0] EXC_VECTOR = 32'h0000_0100
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [2:0]    ctrl;
	logic [31:0]   insn_pc;
	logic [63:0]   opa;
	logic [63:0]   opb;
	logic [31:0]   cond_reg;
	logic [63:0]   bottom_result_reg;
	logic [63:0]   upper_product_reg;
	logic [63:0]   gpr_result;
	logic [2:0]    exc;
	logic [5:0]    brk_code;
	logic          ext_pending;
	logic [10:0]   ext_imm;
	logic          slot_pending;
	logic [31:0]   slot_target;
	logic          slot_mode;
	div_state_e    div_state;
	logic [6:0]    div_cnt;
	logic [63:0]   div_rem;
	logic [63:0]   div_quo;
	logic [63:0]   div_dvs;
	logic          q_neg;
	logic          r_neg;
	logic          busy;
	logic          access;
	logic          wr_done;
	logic          exec;
	logic [4:0]    op;
	logic          muldiv;
	logic          allowed;
	logic [31:0]   seq_pc;
	logic [31:0]   off8;
	logic [31:0]   off11;
	logic [31:0]   offx;
	logic [31:0]   br_off;
	logic [31:0]   abs_tgt;
	logic signed [127:0] prod_s;
	logic [127:0]  prod_u;
	logic [64:0]   div_shift;
	logic [64:0]   div_diff;
	logic [31:0]   rd_mux;
	logic          rd_ok;
	logic          is_jump;

	assign busy   = (div_state == st_div);
	assign access = psel && penable && !pready;
	assign wr_done = psel && penable && pready && pwrite && !pslverr;
	assign exec   = wr_done && (paddr == OFF_INSN);
	assign op     = pwdata[31:27];
	assign muldiv = (op == OP_SMUL) || (op == OP_UMUL) || (op == OP_SDIV) || (op == OP_UDIV);
	assign allowed = ctrl[CTRL_M64] || ctrl[CTRL_KERN];
	assign is_jump = (op == OP_JUMP_LINK) || (op == OP_JUMP_XCHG) ||
		(op == OP_REG_JUMP) || (op == OP_REG_JLINK);
	// the 26-bit absolute form is a two-halfword instruction
	assign seq_pc = insn_pc + (((op == OP_JUMP_LINK) || (op == OP_JUMP_XCHG)) ? LEN_WORD : LEN_HALF);
	assign off8   = {{23{pwdata[7]}}, pwdata[7:0], 1'b0};
	assign off11  = {{20{pwdata[10]}}, pwdata[10:0], 1'b0};
	assign offx   = {{15{ext_imm[10]}}, ext_imm, pwdata[4:0], 1'b0};
	assign br_off = ext_pending ? offx : ((op == OP_BR_ALWAYS) ? off11 : off8);
	assign abs_tgt = {seq_pc[31:28], pwdata[25:0], 2'b00};
	assign prod_s = $signed(opa) * $signed(opb);
	assign prod_u = {64'h0, opa} * {64'h0, opb};
	assign div_shift = {div_rem, div_quo[63]};
	assign div_diff  = div_shift - {1'b0, div_dvs};

	// registered answer: one wait cycle, more for an instruction write while a divide is running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= access && !(pwrite && (paddr == OFF_INSN) && busy);
			pslverr <= access && !rd_ok;
			prdata  <= (access && !pwrite) ? rd_mux : 32'h0;
		end
	end

	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (paddr)
			OFF_CTRL:   rd_mux = {29'h0, ctrl};
			OFF_INSN:   rd_mux = 32'h0;
			OFF_PC:     rd_mux = insn_pc;
			OFF_OPA_L:  rd_mux = opa[31:0];
			OFF_OPA_H:  rd_mux = opa[63:32];
			OFF_OPB_L:  rd_mux = opb[31:0];
			OFF_OPB_H:  rd_mux = opb[63:32];
			OFF_COND:   rd_mux = cond_reg;
			OFF_BOT_L:  rd_mux = bottom_result_reg[31:0];
			OFF_BOT_H:  rd_mux = bottom_result_reg[63:32];
			OFF_UPP_L:  rd_mux = upper_product_reg[31:0];
			OFF_UPP_H:  rd_mux = upper_product_reg[63:32];
			OFF_STATUS: rd_mux = {18'h0, brk_code, 2'b00, slot_pending, ext_pending,
				busy, exc};
			OFF_GPR_L:  rd_mux = gpr_result[31:0];
			OFF_GPR_H:  rd_mux = gpr_result[63:32];
			default:    rd_ok = 1'b0;
		endcase
	end

	// operand and condition registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa      <= 64'h0;
			opb      <= 64'h0;
			cond_reg <= 32'h0;
		end else if (wr_done) begin
			case (paddr)
				OFF_OPA_L: opa[31:0]  <= pwdata;
				OFF_OPA_H: opa[63:32] <= pwdata;
				OFF_OPB_L: opb[31:0]  <= pwdata;
				OFF_OPB_H: opb[63:32] <= pwdata;
				OFF_COND:  cond_reg   <= pwdata;
				default: ;
			endcase
		end
	end

	// exception flags: a new trap in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc      <= 3'h0;
			brk_code <= 6'h0;
		end else begin
			if (wr_done && (paddr == OFF_STATUS))
				exc <= exc & ~pwdata[2:0];
			if (exec && muldiv && !allowed)
				exc[ST_RI] <= 1'b1;
			if (exec && (op == OP_BREAKPT)) begin
				exc[ST_BRK] <= 1'b1;
				brk_code    <= pwdata[5:0];
			end
			// a trap in the slot cancels the jump, so no fetch fault either
			if (exec && slot_pending && !slot_mode && (slot_target[1:0] != 2'b00) &&
					(op != OP_BREAKPT) && !(muldiv && !allowed))
				exc[ST_ADDR] <= 1'b1;
		end
	end

	// control flow, isa mode and transfers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl         <= RST_CTRL;
			insn_pc      <= RST_PC;
			ext_pending  <= 1'b0;
			ext_imm      <= 11'h0;
			slot_pending <= 1'b0;
			slot_target  <= 32'h0;
			slot_mode    <= 1'b0;
			gpr_result   <= 64'h0;
		end else if (wr_done && (paddr == OFF_CTRL)) begin
			ctrl <= pwdata[2:0];
		end else if (wr_done && (paddr == OFF_PC)) begin
			insn_pc <= pwdata;
		end else if (exec) begin
			// pair halves advance by two bytes each; word alignment is only required of jump targets with the isa bit clear
			ext_pending <= (op == OP_EXT_PREFIX);
			ext_imm     <= pwdata[10:0];
			insn_pc     <= seq_pc;
			if (op == OP_BREAKPT) begin
				insn_pc      <= EXC_VECTOR;
				slot_pending <= 1'b0;
			end else if (muldiv && !allowed) begin
				insn_pc      <= EXC_VECTOR;
				slot_pending <= 1'b0;
			end else if (slot_pending) begin
				// the slot instruction ran; now move to the stored target
				slot_pending    <= 1'b0;
				// a move in the slot still happens as the jump completes; a branch or jump there is dropped
				if (op == OP_MOVE_BOT)
					gpr_result <= bottom_result_reg;
				if (op == OP_MOVE_UPP)
					gpr_result <= upper_product_reg;
				ctrl[CTRL_ISA]  <= slot_mode;
				insn_pc         <= slot_mode ? {slot_target[31:1], 1'b0} : slot_target;
				if (!slot_mode && (slot_target[1:0] != 2'b00))
					insn_pc <= EXC_VECTOR;
			end else begin
				case (op)
					OP_MOVE_BOT: gpr_result <= bottom_result_reg;
					OP_MOVE_UPP: gpr_result <= upper_product_reg;
					OP_JUMP_LINK, OP_JUMP_XCHG: begin
						slot_pending <= 1'b1;
						slot_target  <= abs_tgt;
						slot_mode    <= (op == OP_JUMP_XCHG) ? !ctrl[CTRL_ISA] : ctrl[CTRL_ISA];
						gpr_result   <= {32'h0, seq_pc[31:1] + 31'h1, ctrl[CTRL_ISA]};
					end
					OP_REG_JUMP, OP_REG_JLINK: begin
						slot_pending <= 1'b1;
						slot_target  <= opa[31:0];
						slot_mode    <= opa[0];
						if (op == OP_REG_JLINK)
							gpr_result <= {32'h0, seq_pc[31:1] + 31'h1, ctrl[CTRL_ISA]};
					end
					OP_BR_RZERO: if (opa == 64'h0) insn_pc <= seq_pc + br_off;
					OP_BR_RNZ:   if (opa != 64'h0) insn_pc <= seq_pc + br_off;
					OP_BR_CZERO: if (cond_reg == 32'h0) insn_pc <= seq_pc + br_off;
					OP_BR_CNZ:   if (cond_reg != 32'h0) insn_pc <= seq_pc + br_off;
					OP_BR_ALWAYS: insn_pc <= seq_pc + br_off;
					default: ;
				endcase
			end
		end
	end

	// result registers: multiply in one step, divide one bit a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_state         <= st_idle;
			div_cnt           <= 7'h0;
			div_rem           <= 64'h0;
			div_quo           <= 64'h0;
			div_dvs           <= 64'h0;
			q_neg             <= 1'b0;
			r_neg             <= 1'b0;
			bottom_result_reg <= 64'h0;
			upper_product_reg <= 64'h0;
		end else begin
			case (div_state)
				st_idle: begin
					// a multiply or divide in a delay slot still runs
					if (exec && allowed) begin
						case (op)
							OP_SMUL: {upper_product_reg, bottom_result_reg} <= prod_s;
							OP_UMUL: {upper_product_reg, bottom_result_reg} <= prod_u;
							OP_SDIV, OP_UDIV: begin
								q_neg     <= (op == OP_SDIV) && (opa[63] ^ opb[63]);
								r_neg     <= (op == OP_SDIV) && opa[63];
								div_quo   <= ((op == OP_SDIV) && opa[63]) ? -opa : opa;
								div_dvs   <= ((op == OP_SDIV) && opb[63]) ? -opb : opb;
								div_rem   <= 64'h0;
								div_cnt   <= 7'h0;
								div_state <= st_div;
							end
							default: ;
						endcase
					end
				end
				st_div: begin
					// zero divisor is left to run; its result is undefined anyway
					div_cnt <= div_cnt + 7'h1;
					if (!div_diff[64]) begin
						div_rem <= div_diff[63:0];
						div_quo <= {div_quo[62:0], 1'b1};
					end else begin
						div_rem <= div_shift[63:0];
						div_quo <= {div_quo[62:0], 1'b0};
					end
					if (div_cnt == DIV_LAST) begin
						div_state <= st_idle;
						bottom_result_reg <= q_neg ? -{div_quo[62:0], !div_diff[64]}
							: {div_quo[62:0], !div_diff[64]};
						upper_product_reg <= r_neg ? -(div_diff[64] ? div_shift[63:0] : div_diff[63:0])
							: (div_diff[64] ? div_shift[63:0] : div_diff[63:0]);
					end
				end
				default: div_state <= st_idle;
			endcase
		end
	end

	sequence s_div_run;
		busy [*8] ##0 busy ##56 busy;
	endsequence

	a_div_timing: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && allowed && (op == OP_SDIV || op == OP_UDIV))
		|=> s_div_run ##1 !busy)
		else $error("divide did not finish in 64 cycles");
	a_umul_result: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && allowed && op == OP_UMUL && !busy)
		|=> {upper_product_reg, bottom_result_reg} == $past(opa) * $past(opb))
		else $error("unsigned product wrong");
	a_smul_result: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && allowed && op == OP_SMUL)
		|=> $signed({upper_product_reg, bottom_result_reg}) ==
			$signed($past(opa)) * $signed($past(opb)))
		else $error("signed product wrong");
	a_mode_trap: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && muldiv && !allowed)
		|=> exc[ST_RI] && !busy && insn_pc == EXC_VECTOR && $stable(bottom_result_reg))
		else $error("reserved trap missing");
	a_taken_skip: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && !ext_pending && op == OP_BR_RNZ && opa != 64'h0)
		|=> insn_pc == $past(insn_pc) + LEN_HALF + $past(off8) && !slot_pending)
		else $error("taken branch target wrong");
	a_jump_slot: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && op == OP_REG_JUMP)
		|=> slot_pending && insn_pc == $past(insn_pc) + LEN_HALF)
		else $error("delay slot not kept");
	a_link_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && op == OP_JUMP_LINK)
		|=> gpr_result[0] == $past(ctrl[CTRL_ISA]) && slot_mode == gpr_result[0])
		else $error("link mode bit wrong");
	a_break_trap: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_BREAKPT)
		|=> exc[ST_BRK] && insn_pc == EXC_VECTOR && brk_code == $past(pwdata[5:0]))
		else $error("breakpoint trap missing");
	a_cond_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && !ext_pending && op == OP_BR_CZERO && cond_reg != 32'h0)
		|=> insn_pc == $past(insn_pc) + LEN_HALF)
		else $error("condition-zero branch taken on nonzero");
	a_move_bottom: assert property (@(posedge pclk) disable iff (!presetn)
		(exec && !slot_pending && op == OP_MOVE_BOT) |=> gpr_result == $past(bottom_result_reg))
		else $error("move from bottom result wrong");
	a_insn_stall: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && paddr == OFF_INSN && busy) |=> !pready)
		else $error("instruction taken while dividing");
endmodule : compact_isa_exec

/* dv/tb_compact_isa_exec.sv */
// self-checking testbench for the compact-isa execution unit
module tb_compact_isa_exec import cexec_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] VEC = 32'h0000_0100;
	localparam logic [31:0] NOP = 32'hf800_0000;
	localparam logic [31:0] P   = 32'h3000_0100;
	localparam logic [31:0] TJ  = {P[31:28] + 4'h0, 26'h012_3456, 2'b00};
	localparam logic [31:0] LJ  = P + 32'h6;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] q;
	logic [63:0] q64;
	logic        e;
	int          err_total;
	int          n_checks;

	compact_isa_exec #(.EXC_VECTOR(VEC)) i_compact_isa_exec (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	// request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 200) begin
			err_total++;
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk({31'h0, e, q}, {32'h0, x});
	endtask : rdc

	task automatic wr64(input logic [7:0] a, input logic [63:0] d);
		wr(a, d[31:0]);
		wr(a + 8'h04, d[63:32]);
	endtask : wr64

	task automatic rd64(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		q64[31:0] = q;
		apb(1'b0, a + 8'h04, 32'h0);
		q64[63:32] = q;
	endtask : rd64

	function automatic logic [31:0] ins(input logic [4:0] op, input logic [25:0] f);
		return {op, 1'b0, f};
	endfunction : ins

	task automatic t_reset();
		rdc(OFF_CTRL, {29'h0, RST_CTRL});
		rdc(OFF_PC, RST_PC);
		rdc(OFF_STATUS, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk({31'h0, e, q}, {31'h0, 1'b1, 32'h0});
		wr(OFF_BOT_L, 32'h55);
		rdc(OFF_BOT_L, 32'h0);
	endtask : t_reset

	task automatic t_muldiv();
		logic [63:0]  a;
		logic [63:0]  b;
		logic [127:0] p;
		logic [63:0]  lo;
		logic [63:0]  hi;
		a = 64'hffff_ffff_ffff_ff9c;
		b = 64'h0000_0000_0000_0007;
		for (int op = 2; op <= 5; op++) begin
			// odd opcodes run in kernel mode, even in 64-bit mode
			wr(OFF_CTRL, op[0] ? 32'h4 : 32'h2);
			wr64(OFF_OPA_L, a);
			wr64(OFF_OPB_L, b);
			wr(OFF_INSN, ins(5'(op), 26'h0));
			// a running divide holds this write off until it ends
			wr(OFF_INSN, NOP);
			repeat (80) begin
				apb(1'b0, OFF_STATUS, 32'h0);
				if (q[ST_BUSY] === 1'b0) break;
			end
			p = (op == 2) ? {{64{a[63]}}, a} * {{64{b[63]}}, b} : {64'h0, a} * {64'h0, b};
			// signed divide kept out of a mixed conditional, which would make it unsigned
			lo = p[63:0];
			hi = p[127:64];
			if (op == 4) begin
				lo = $signed(a) / $signed(b);
				hi = $signed(a) % $signed(b);
			end else if (op == 5) begin
				lo = a / b;
				hi = a % b;
			end
			rd64(OFF_BOT_L);
			chk(q64, lo);
			rd64(OFF_UPP_L);
			chk(q64, hi);
			rdc(OFF_STATUS, 32'h0);
			wr(OFF_INSN, ins(OP_MOVE_BOT, 26'h0));
			rd64(OFF_GPR_L);
			chk(q64, lo);
			wr(OFF_INSN, ins(OP_MOVE_UPP, 26'h0));
			rd64(OFF_GPR_L);
			chk(q64, hi);
			wr(OFF_INSN, NOP);
			wr(OFF_INSN, NOP);
			wr(OFF_CTRL, 32'h0);
			wr(OFF_PC, 32'h40);
			wr(OFF_INSN, ins(5'(op), 26'h0));
			rdc(OFF_STATUS, 32'h1);
			rdc(OFF_PC, VEC);
			wr(OFF_STATUS, 32'h7);
		end
	endtask : t_muldiv

	task automatic t_branch();
		logic [4:0]  op [9] = '{OP_BR_RZERO, OP_BR_RZERO, OP_BR_RNZ, OP_BR_RNZ, OP_BR_CZERO,
			OP_BR_CZERO, OP_BR_CNZ, OP_BR_CNZ, OP_BR_ALWAYS};
		logic [31:0] cv [9] = '{9, 9, 9, 9, 0, 9, 9, 0, 9};
		logic [10:0] im;
		logic [31:0] off;
		im = 11'h5f0;
		for (int i = 0; i < 9; i++) begin
			// a nonzero upper half alone must count as nonzero
			off = (i == 8) ? {{20{im[10]}}, im, 1'b0} : {{23{im[7]}}, im[7:0], 1'b0};
			wr(OFF_PC, 32'h1000);
			wr64(OFF_OPA_L, (i == 0 || i == 3) ? 64'h0 : 64'h1_0000_0000);
			wr(OFF_COND, cv[i]);
			wr(OFF_INSN, ins(op[i], {15'h0, im}));
			rdc(OFF_PC, i[0] ? 32'h1002 : 32'h1002 + off);
			rdc(OFF_STATUS, 32'h0);
		end
	endtask : t_branch

	task automatic t_ext();
		wr(OFF_PC, 32'h1002);
		wr(OFF_INSN, ins(OP_EXT_PREFIX, 26'h7ff));
		rdc(OFF_STATUS, 32'h10);
		rdc(OFF_PC, 32'h1004);
		wr(OFF_INSN, ins(OP_BR_ALWAYS, 26'h010));
		rdc(OFF_PC, 32'h1006 + {{15{1'b1}}, 16'hfff0, 1'b0});
		rdc(OFF_STATUS, 32'h0);
	endtask : t_ext

	task automatic jmp(input logic [4:0] op, input logic [31:0] ctl, input logic [63:0] src,
			input logic [31:0] lnk, input logic [31:0] tgt, input logic [31:0] ctl2,
			input logic [31:0] st2);
		wr(OFF_CTRL, ctl);
		wr(OFF_PC, P);
		wr64(OFF_OPA_L, src);
		wr(OFF_INSN, ins(op, 26'h012_3456));
		rdc(OFF_CTRL, ctl);
		rdc(OFF_STATUS, 32'h20);
		if (op != OP_REG_JUMP) begin
			rd64(OFF_GPR_L);
			chk({32'h0, q64[31:0]}, {32'h0, lnk});
		end
		wr(OFF_INSN, NOP);
		rdc(OFF_PC, tgt);
		rdc(OFF_CTRL, ctl2);
		rdc(OFF_STATUS, st2);
		wr(OFF_STATUS, 32'h7);
	endtask : jmp

	task automatic t_jump();
		jmp(OP_JUMP_LINK, 32'h0, 64'h0, LJ, TJ, 32'h0, 32'h0);
		jmp(OP_JUMP_LINK, 32'h1, 64'h0, LJ | 32'h1, TJ, 32'h1, 32'h0);
		jmp(OP_JUMP_XCHG, 32'h0, 64'h0, LJ, TJ, 32'h1, 32'h0);
		jmp(OP_JUMP_XCHG, 32'h1, 64'h0, LJ | 32'h1, TJ, 32'h0, 32'h0);
		jmp(OP_REG_JUMP, 32'h0, 64'h2001, 32'h0, 32'h2000, 32'h1, 32'h0);
		jmp(OP_REG_JLINK, 32'h1, 64'h2004, P + 32'h5, 32'h2004, 32'h0, 32'h0);
		jmp(OP_REG_JLINK, 32'h0, 64'h2001, P + 32'h4, 32'h2000, 32'h1, 32'h0);
		jmp(OP_REG_JUMP, 32'h1, 64'h2006, 32'h0, VEC, 32'h0, 32'h2);
	endtask : t_jump

	task automatic t_break();
		wr(OFF_PC, 32'h40);
		wr(OFF_INSN, ins(OP_BREAKPT, 26'h0ea));
		rdc(OFF_PC, VEC);
		rdc(OFF_STATUS, 32'h2a04);
		wr(OFF_STATUS, 32'h7);
		// a trap in the delay slot must cancel the pending jump
		wr(OFF_CTRL, 32'h0);
		wr(OFF_PC, P);
		wr(OFF_INSN, ins(OP_JUMP_LINK, 26'h012_3456));
		wr(OFF_INSN, ins(OP_BREAKPT, 26'h03f));
		rdc(OFF_PC, VEC);
		rdc(OFF_STATUS, 32'h3f04);
	endtask : t_break

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial begin
		repeat (30000) @(posedge pclk);
		err_total++;
		stop_test();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_muldiv();
		t_branch();
		t_ext();
		t_jump();
		t_break();
		stop_test();
	end
endmodule : tb_compact_isa_exec
